// [rtl/aan_adv_reg.sv]
// auto-negotiation advertisement register with link code word and forced-mode outputs
//
// Contract
// R01 - next-page bit 15 is read/write, resets clear, advertised when set
// R02 - reserved bits 14 and 12:10 always read as zero
// R03 - management writes reserved bits with their default values on every write; the bench also writes 16'hFFFF and 16'h5D22 with keep_rsvd off
// R04 - override-writable bits ignore writes unless command-override input is one
// R05 - remote-fault bit 13 follows local link fault and goes in code word
// R06 - 100BASE-T4 bit 9 is always zero
// R07 - bits 8..5 advertise 100FD, 100HD, 10FD, 10HD; one means advertised
// R08 - in hardware mode ability bits 8..5 are read-only
// R09 - hardware mode, negotiation pin low: skip negotiation, idle at pin speed/duplex
// R10 - hardware mode, negotiation pin high: negotiate after reset, one-hot pin ability
// R11 - status capability bits always show all supported abilities
// R12 - software mode ability bits are override-writable, default all ones
// R13 - software mode, negotiation disabled: idle at control speed and duplex bits
// R14 - software mode, negotiation enabled: advertise exactly the ability bits
// R15 - management may change abilities then restart negotiation to apply them
// R16 - selector field holds 00001b and is sent as message type
// R17 - negotiation enabled: link code word built from register contents
// R18 - read returns every implemented bit, fixed and reserved bits constant
`timescale 1ns/1ps
module aan_adv_reg (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [aan_pkg::ADDR_W-1:0] mgmt_addr_i,
    input wire logic [aan_pkg::REG_W-1:0] mgmt_wdata_i,
    output logic [aan_pkg::REG_W-1:0] mgmt_rdata_o,
    input wire logic command_override_i,
    input wire logic hardware_software_mode_pin_i,
    input wire logic autoneg_select_pin_i,
    input wire logic speed_select_pin_i,
    input wire logic duplex_select_pin_i,
    input wire logic ctrl_autoneg_enable_i,
    input wire logic ctrl_speed_100_i,
    input wire logic ctrl_full_duplex_i,
    input wire logic autoneg_restart_i,
    input wire logic link_fault_i,
    output logic [aan_pkg::REG_W-1:0] link_code_word_o,
    output logic autoneg_start_o,
    output logic autoneg_active_o,
    output logic forced_idle_o,
    output logic forced_speed_100_o,
    output logic forced_full_duplex_o,
    output logic [aan_pkg::TAF_W-1:0] status_abilities_o
);
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        aan_pkg::aan_state_t state;
        logic next_page;
        logic rsvd_ack;
        logic remote_fault;
        logic [aan_pkg::RSVD_W-1:0] rsvd;
        logic [aan_pkg::TAF_W-1:0] technology_ability_field;
        logic [aan_pkg::SEL_W-1:0] sel;
        logic [aan_pkg::REG_W-1:0] rdata;
        logic [aan_pkg::REG_W-1:0] lcw;
        logic start;
        logic forced_100;
        logic forced_fd;
    } aan_regs_t;

    aan_regs_t s_reg;
    aan_regs_t s_next;
    logic [aan_pkg::TAF_W-1:0] pin_ability;
    logic [aan_pkg::REG_W-1:0] adv_view;
    logic [aan_pkg::REG_W-1:0] adv_word;
    logic adv_wr;
    logic an_on;
    logic hw_mode;

    // ability implied by the select pins in hardware mode
    aan_ability_select u_ability (
        .speed_100_i(speed_select_pin_i),
        .full_duplex_i(duplex_select_pin_i),
        .ability_o(pin_ability)
    );

    // mode decode and register images
    always_comb begin
        hw_mode = ~hardware_software_mode_pin_i;
        an_on = hw_mode ? autoneg_select_pin_i : ctrl_autoneg_enable_i;
        adv_wr = mgmt_wr_i && (mgmt_addr_i == aan_pkg::ADV_ADDR);
        // management view: reserved bits and bit 9 read as zero
        adv_view = '0; // R02 R06
        adv_view[aan_pkg::NEXT_PAGE_BIT] = s_reg.next_page;
        adv_view[aan_pkg::REMOTE_FAULT_BIT] = s_reg.remote_fault; // R05
        // hardware mode shows the pin choice at once, so the first code word after reset is one-hot
        if (hw_mode) begin
            adv_view[aan_pkg::TAF_HI:aan_pkg::TAF_LO] = pin_ability; // R08 R10
        end else begin
            adv_view[aan_pkg::TAF_HI:aan_pkg::TAF_LO] = s_reg.technology_ability_field; // R07 R12
        end
        adv_view[aan_pkg::SEL_HI:aan_pkg::SEL_LO] = s_reg.sel; // R18
        // transmitted word: acknowledge and reserved positions sent as zero
        adv_word = adv_view; // R17
    end

    // next-state logic for the whole block
    always_comb begin
        s_next = s_reg;
        s_next.rst_meta = 1'b1;
        s_next.rst_sync = s_reg.rst_meta;
        s_next.start = 1'b0;
        // next page is plain read/write
        if (adv_wr) begin
            s_next.next_page = mgmt_wdata_i[aan_pkg::NEXT_PAGE_BIT]; // R01
        end
        // reserved and selector bits take writes only under override
        if (adv_wr && command_override_i) begin
            s_next.rsvd_ack = mgmt_wdata_i[aan_pkg::RSVD_ACK_BIT]; // R04
            s_next.rsvd = mgmt_wdata_i[aan_pkg::RSVD_HI:aan_pkg::RSVD_LO]; // R04
            s_next.sel = mgmt_wdata_i[aan_pkg::SEL_HI:aan_pkg::SEL_LO]; // R04
        end
        // remote fault tracks the local fault detector
        s_next.remote_fault = link_fault_i; // R05
        // ability field: pins in hardware mode, override-write in software mode
        if (hw_mode) begin
            s_next.technology_ability_field = pin_ability; // R08 R10
        end else if (adv_wr && command_override_i) begin
            s_next.technology_ability_field = mgmt_wdata_i[aan_pkg::TAF_HI:aan_pkg::TAF_LO]; // R12
        end
        // registered read data, zero for any other address
        if (mgmt_rd_i) begin
            s_next.rdata = (mgmt_addr_i == aan_pkg::ADV_ADDR) ? adv_view : aan_pkg::RDATA_RST; // R02 R18
        end
        // forced speed and duplex source depends on the mode
        s_next.forced_100 = hw_mode ? speed_select_pin_i : ctrl_speed_100_i; // R09 R13
        s_next.forced_fd = hw_mode ? duplex_select_pin_i : ctrl_full_duplex_i; // R09 R13
        // negotiation sequencer
        unique case (s_reg.state)
            aan_pkg::AAN_INIT: begin
                if (s_reg.rst_sync) begin
                    if (an_on) begin
                        s_next.state = aan_pkg::AAN_NEGOTIATE; // R10
                        s_next.start = 1'b1;
                        s_next.lcw = adv_word; // R14 R17
                    end else begin
                        s_next.state = aan_pkg::AAN_IDLE; // R09 R13
                    end
                end
            end
            aan_pkg::AAN_NEGOTIATE: begin
                if (!an_on) begin
                    s_next.state = aan_pkg::AAN_IDLE;
                end else if (autoneg_restart_i) begin
                    s_next.start = 1'b1; // R15
                    s_next.lcw = adv_word; // R14
                end
            end
            aan_pkg::AAN_IDLE: begin
                if (an_on) begin
                    s_next.state = aan_pkg::AAN_NEGOTIATE;
                    s_next.start = 1'b1;
                    s_next.lcw = adv_word; // R17
                end
            end
            default: begin
                s_next.state = aan_pkg::AAN_INIT;
            end
        endcase
    end

    // one register process: raw reset loads every reset value, the synchronised copy holds state until release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg.rst_meta <= 1'b0;
            s_reg.rst_sync <= 1'b0;
            s_reg.state <= aan_pkg::AAN_INIT;
            s_reg.next_page <= aan_pkg::NEXT_PAGE_RST; // R01
            s_reg.rsvd_ack <= aan_pkg::RSVD_BIT_RST;
            s_reg.remote_fault <= 1'b0;
            s_reg.rsvd <= aan_pkg::RSVD_RST;
            s_reg.technology_ability_field <= aan_pkg::TAF_RST; // R12
            s_reg.sel <= aan_pkg::SEL_IEEE_8023; // R16
            s_reg.rdata <= aan_pkg::RDATA_RST;
            s_reg.lcw <= aan_pkg::RDATA_RST;
            s_reg.start <= 1'b0;
            s_reg.forced_100 <= 1'b0;
            s_reg.forced_fd <= 1'b0;
        end else if (!s_reg.rst_sync) begin
            s_reg.rst_meta <= s_next.rst_meta;
            s_reg.rst_sync <= s_next.rst_sync;
            s_reg.state <= aan_pkg::AAN_INIT;
            s_reg.next_page <= aan_pkg::NEXT_PAGE_RST;
            s_reg.rsvd_ack <= aan_pkg::RSVD_BIT_RST;
            s_reg.remote_fault <= 1'b0;
            s_reg.rsvd <= aan_pkg::RSVD_RST;
            s_reg.technology_ability_field <= aan_pkg::TAF_RST;
            s_reg.sel <= aan_pkg::SEL_IEEE_8023;
            s_reg.rdata <= aan_pkg::RDATA_RST;
            s_reg.lcw <= aan_pkg::RDATA_RST;
            s_reg.start <= 1'b0;
            s_reg.forced_100 <= 1'b0;
            s_reg.forced_fd <= 1'b0;
        end else begin
            s_reg.rst_meta <= s_next.rst_meta;
            s_reg.rst_sync <= s_next.rst_sync;
            s_reg.state <= s_next.state;
            s_reg.next_page <= s_next.next_page;
            s_reg.rsvd_ack <= s_next.rsvd_ack;
            s_reg.remote_fault <= s_next.remote_fault;
            s_reg.rsvd <= s_next.rsvd;
            s_reg.technology_ability_field <= s_next.technology_ability_field;
            s_reg.sel <= s_next.sel;
            s_reg.rdata <= s_next.rdata;
            s_reg.lcw <= s_next.lcw;
            s_reg.start <= s_next.start;
            s_reg.forced_100 <= s_next.forced_100;
            s_reg.forced_fd <= s_next.forced_fd;
        end
    end

    // outputs
    assign mgmt_rdata_o = s_reg.rdata;
    assign link_code_word_o = s_reg.lcw; // R17
    assign autoneg_start_o = s_reg.start;
    assign autoneg_active_o = (s_reg.state == aan_pkg::AAN_NEGOTIATE);
    assign forced_idle_o = (s_reg.state == aan_pkg::AAN_IDLE); // R09 R13
    assign forced_speed_100_o = s_reg.forced_100;
    assign forced_full_duplex_o = s_reg.forced_fd;
    assign status_abilities_o = aan_pkg::TAF_SUPPORTED; // R11
endmodule

// [rtl/aan_pkg.sv]
// shared constants for the auto-negotiation advertisement register block
package aan_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADV_ADDR = 5'h04;
    // bit positions of the advertisement register
    localparam int NEXT_PAGE_BIT = 15;
    localparam int RSVD_ACK_BIT = 14;
    localparam int REMOTE_FAULT_BIT = 13;
    localparam int RSVD_HI = 12;
    localparam int RSVD_LO = 10;
    localparam int T4_BIT = 9;
    localparam int TAF_HI = 8;
    localparam int TAF_LO = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 0;
    localparam int TAF_W = 4;
    localparam int SEL_W = 5;
    localparam int RSVD_W = 3;
    // reset values
    localparam logic NEXT_PAGE_RST = 1'b0;
    localparam logic RSVD_BIT_RST = 1'b0;
    localparam logic [RSVD_W-1:0] RSVD_RST = 3'h0;
    localparam logic [TAF_W-1:0] TAF_RST = 4'hF;
    localparam logic [SEL_W-1:0] SEL_IEEE_8023 = 5'h01;
    localparam logic [REG_W-1:0] RDATA_RST = 16'h0000;
    // one-hot positions inside the technology ability field
    localparam logic [TAF_W-1:0] TAF_100_FD = 4'h8;
    localparam logic [TAF_W-1:0] TAF_100_HD = 4'h4;
    localparam logic [TAF_W-1:0] TAF_10_FD = 4'h2;
    localparam logic [TAF_W-1:0] TAF_10_HD = 4'h1;
    // every ability the device supports, for the status bits
    localparam logic [TAF_W-1:0] TAF_SUPPORTED = 4'hF;
    typedef enum logic [1:0] {
        AAN_INIT = 2'b00,
        AAN_NEGOTIATE = 2'b01,
        AAN_IDLE = 2'b10
    } aan_state_t;
endpackage

// [rtl/aan_ability_select.sv]
// one-hot ability chosen by the speed and duplex select pins
`timescale 1ns/1ps
module aan_ability_select (
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    output logic [aan_pkg::TAF_W-1:0] ability_o
);
    // exactly one of the four abilities is set
    always_comb begin
        unique case ({speed_100_i, full_duplex_i})
            2'b11: ability_o = aan_pkg::TAF_100_FD;
            2'b10: ability_o = aan_pkg::TAF_100_HD;
            2'b01: ability_o = aan_pkg::TAF_10_FD;
            2'b00: ability_o = aan_pkg::TAF_10_HD;
        endcase
    end
endmodule

// [testbench/aan_adv_reg_properties.sv]
// concurrent checks on the advertisement register ports
`timescale 1ns/1ps
module aan_adv_reg_properties (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mgmt_rd_i,
    input wire logic [aan_pkg::REG_W-1:0] mgmt_rdata_o,
    input wire logic hardware_software_mode_pin_i,
    input wire logic duplex_select_pin_i,
    input wire logic ctrl_speed_100_i,
    input wire logic autoneg_restart_i,
    input wire logic [aan_pkg::REG_W-1:0] link_code_word_o,
    input wire logic autoneg_start_o,
    input wire logic autoneg_active_o,
    input wire logic forced_idle_o,
    input wire logic forced_speed_100_o,
    input wire logic forced_full_duplex_o,
    input wire logic [aan_pkg::TAF_W-1:0] status_abilities_o
);
    // single clock domain for every check
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // trigger conditions for multi-step checks
    sequence s_restart; autoneg_active_o && autoneg_restart_i; endsequence
    sequence s_idle_restart; forced_idle_o && autoneg_restart_i; endsequence
    sequence s_sw_idle; forced_idle_o && hardware_software_mode_pin_i && $stable(ctrl_speed_100_i); endsequence
    sequence s_hw_idle; forced_idle_o && !hardware_software_mode_pin_i && $stable(duplex_select_pin_i); endsequence
    a_rsvd_read_zero: assert property ({mgmt_rdata_o[14], mgmt_rdata_o[12:9]} == 5'h00)
        else $error("reserved read bits nonzero");
    a_lcw_fixed_zero: assert property ({link_code_word_o[14], link_code_word_o[12:9]} == 5'h00)
        else $error("code word reserved bits nonzero");
    a_status_all_set: assert property (status_abilities_o == 4'hF)
        else $error("status abilities changed");
    a_lcw_holds: assert property (!autoneg_start_o |-> $stable(link_code_word_o))
        else $error("code word moved without start");
    a_rdata_holds: assert property (!mgmt_rd_i |=> $stable(mgmt_rdata_o))
        else $error("read data moved without read");
    a_hw_one_hot: assert property (autoneg_start_o && !hardware_software_mode_pin_i |-> $onehot(link_code_word_o[8:5]))
        else $error("hardware mode ability not one-hot");
    a_restart_starts: assert property (s_restart |=> autoneg_start_o)
        else $error("restart gave no start");
    a_idle_refuses: assert property (s_idle_restart |=> !autoneg_start_o && forced_idle_o)
        else $error("restart accepted while idle");
    a_sw_speed_src: assert property (s_sw_idle |-> forced_speed_100_o == ctrl_speed_100_i)
        else $error("forced speed not from control bit");
    a_hw_duplex_src: assert property (s_hw_idle |-> forced_full_duplex_o == duplex_select_pin_i)
        else $error("forced duplex not from pin");
endmodule
bind aan_adv_reg aan_adv_reg_properties aan_adv_reg_properties_i (.clock_i, .rst_n_i, .mgmt_rd_i, .mgmt_rdata_o,
    .hardware_software_mode_pin_i, .duplex_select_pin_i, .ctrl_speed_100_i, .autoneg_restart_i, .link_code_word_o,
    .autoneg_start_o, .autoneg_active_o, .forced_idle_o, .forced_speed_100_o, .forced_full_duplex_o, .status_abilities_o);

// [testbench/aan_mgmt_model.sv]
// station management model driving the register strobes
`timescale 1ns/1ps
module aan_mgmt_model (
    input wire logic clock_i,
    output logic mgmt_wr_o,
    output logic mgmt_rd_o,
    output logic [aan_pkg::ADDR_W-1:0] mgmt_addr_o,
    output logic [aan_pkg::REG_W-1:0] mgmt_wdata_o,
    input wire logic [aan_pkg::REG_W-1:0] mgmt_rdata_i
);
    // idle bus levels at time zero
    initial begin
        mgmt_wr_o = 1'b0;
        mgmt_rd_o = 1'b0;
        mgmt_addr_o = 5'h1F;
        mgmt_wdata_o = 16'hA5A5;
    end
    // one-cycle write; keep_rsvd puts reserved bits at their defaults
    task automatic write_reg(input logic [4:0] addr, input logic [15:0] data, input logic keep_rsvd);
        @(posedge clock_i);
        #1;
        mgmt_addr_o = addr;
        mgmt_wdata_o = keep_rsvd ? (data & 16'hA1FF) : data;
        mgmt_wr_o = 1'b1;
        @(posedge clock_i);
        #1;
        mgmt_wr_o = 1'b0;
        mgmt_addr_o = ~addr;
        mgmt_wdata_o = ~mgmt_wdata_o;
    endtask
    // one-cycle read, data taken after the read edge
    task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
        @(posedge clock_i);
        #1;
        mgmt_addr_o = addr;
        mgmt_rd_o = 1'b1;
        @(posedge clock_i);
        #1;
        mgmt_rd_o = 1'b0;
        mgmt_addr_o = ~addr;
        data = mgmt_rdata_i;
    endtask
endmodule

// [testbench/aan_adv_reg_tb.sv]
// self-checking bench for the advertisement register
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module aan_adv_reg_tb;
    logic clock_i, rst_n_i, mgmt_wr_i, mgmt_rd_i, command_override_i, hardware_software_mode_pin_i;
    logic autoneg_select_pin_i, speed_select_pin_i, duplex_select_pin_i, ctrl_autoneg_enable_i, ctrl_speed_100_i;
    logic ctrl_full_duplex_i, autoneg_restart_i, link_fault_i, autoneg_start_o, autoneg_active_o, forced_idle_o;
    logic forced_speed_100_o, forced_full_duplex_o;
    logic [4:0] mgmt_addr_i;
    logic [15:0] mgmt_wdata_i, mgmt_rdata_o, link_code_word_o, d;
    logic [3:0] status_abilities_o;
    int error_cnt = 0;
    int checks = 0;
    // design and management model
    aan_adv_reg aan_adv_reg_i (.clock_i, .rst_n_i, .mgmt_wr_i, .mgmt_rd_i, .mgmt_addr_i, .mgmt_wdata_i, .mgmt_rdata_o,
        .command_override_i, .hardware_software_mode_pin_i, .autoneg_select_pin_i, .speed_select_pin_i,
        .duplex_select_pin_i, .ctrl_autoneg_enable_i, .ctrl_speed_100_i, .ctrl_full_duplex_i, .autoneg_restart_i,
        .link_fault_i, .link_code_word_o, .autoneg_start_o, .autoneg_active_o, .forced_idle_o, .forced_speed_100_o,
        .forced_full_duplex_o, .status_abilities_o);
    aan_mgmt_model aan_mgmt_model_i (.clock_i, .mgmt_wr_o(mgmt_wr_i), .mgmt_rd_o(mgmt_rd_i), .mgmt_addr_o(mgmt_addr_i),
        .mgmt_wdata_o(mgmt_wdata_i), .mgmt_rdata_i(mgmt_rdata_o));
    // 100 ns clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // watchdog well past the expected run
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    // reset with mode pins and control bits set up beforehand
    task automatic do_reset(input logic hw_n, input logic an, input logic spd, input logic dpx);
        rst_n_i = 1'b0;
        hardware_software_mode_pin_i = hw_n;
        autoneg_select_pin_i = an;
        ctrl_autoneg_enable_i = an;
        speed_select_pin_i = spd;
        ctrl_speed_100_i = spd;
        duplex_select_pin_i = dpx;
        ctrl_full_duplex_i = dpx;
        command_override_i = 1'b0;
        link_fault_i = 1'b0;
        repeat (20) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
    endtask
    // one-cycle restart request, then let the start land
    task automatic restart();
        @(posedge clock_i);
        #1 autoneg_restart_i = 1'b1;
        @(posedge clock_i);
        #1 autoneg_restart_i = 1'b0;
        @(posedge clock_i);
        #1;
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // test sequence
    initial begin
        autoneg_restart_i = 1'b0;
        do_reset(1'b1, 1'b1, 1'b0, 1'b0);
        aan_mgmt_model_i.read_reg(5'h04, d);
        `CHK(d, 16'h01E1)
        `CHK(status_abilities_o, 4'hF)
        aan_mgmt_model_i.write_reg(5'h04, 16'hFFFF, 1'b0);
        aan_mgmt_model_i.read_reg(5'h04, d);
        `CHK(d, 16'h81E1)
        command_override_i = 1'b1;
        aan_mgmt_model_i.write_reg(5'h04, 16'h5D22, 1'b0);
        aan_mgmt_model_i.read_reg(5'h04, d);
        `CHK(d, 16'h0122)
        aan_mgmt_model_i.write_reg(5'h04, 16'h0121, 1'b1);
        link_fault_i = 1'b1;
        restart();
        `CHK(link_code_word_o, 16'h2121)
        aan_mgmt_model_i.write_reg(5'h05, 16'hFFFF, 1'b0);
        aan_mgmt_model_i.read_reg(5'h05, d);
        `CHK(d, 16'h0000)
        aan_mgmt_model_i.read_reg(5'h04, d);
        `CHK(d, 16'h2121)
        $display("test software_mode done");
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b0, 1'b1, i[1], i[0]);
            `CHK(link_code_word_o[8:5], 4'h1 << i)
            `CHK(autoneg_active_o, 1'b1)
            command_override_i = 1'b1;
            aan_mgmt_model_i.write_reg(5'h04, 16'h01E1, 1'b1);
            aan_mgmt_model_i.read_reg(5'h04, d);
            `CHK(d[8:5], 4'h1 << i)
        end
        $display("test hardware_mode done");
        do_reset(1'b0, 1'b0, 1'b1, 1'b0);
        `CHK({forced_idle_o, autoneg_active_o, forced_speed_100_o, forced_full_duplex_o}, 4'b1010)
        do_reset(1'b1, 1'b0, 1'b0, 1'b1);
        restart();
        `CHK({forced_idle_o, autoneg_active_o, forced_speed_100_o, forced_full_duplex_o}, 4'b1001)
        $display("test forced_modes done");
        stop_test();
    end
endmodule
